// >>> tcs_map.svh
// register pointers, field positions, reset values and timing for the conversion scheduler
//
// How it works
// - rate setting is read at pointer 04h and written at 0Ah, one store.
// - rate code only changes idle time; each conversion keeps its length.
// - rate setting resets to 08h, sixteen conversions per second.
// - codes 00h..08h give 0.0625 per second doubling up to 16 per second.
// - in shutdown any write to pointer 0Fh launches exactly one cycle.
// - one-shot cycle converts local, remote or both per the enable bits.
// - after a one-shot cycle the device returns to shutdown.
// - data byte of a one-shot write is dropped and not stored.
// - enable register at 16h: bit 0 local, bit 1 remote.
// - both enables reset to one; a cleared enable skips that channel.
// - one fault count at 22h governs both channels and both limits.
// - alert asserts once consecutive out-of-limit results equal the count.
// - codes 01h,03h,07h,0Fh need 1,2,3,4 results; reset is 01h.
// - ideality adjust at 23h is signed -128..127, resets to zero.
// - remote result uses ideality 1.008*2088/(2088+adjust).
// - remote offset is added to every remote result.
// - pointer FEh reads a fixed maker identification byte.
// - setting shutdown finishes the running sequence; clearing it resumes.
// - busy status bit is one while a conversion runs, registered one clock behind the sequencer state.
`ifndef TCS_MAP_SVH
`define TCS_MAP_SVH

// ----------------------------------------
// pointers
// ----------------------------------------
`define TCS_PTR_STATUS 8'h02
`define TCS_PTR_CONFIG_RD 8'h03
`define TCS_PTR_RATE_RD 8'h04
`define TCS_PTR_CONFIG_WR 8'h09
`define TCS_PTR_RATE_WR 8'h0A
`define TCS_PTR_ONESHOT 8'h0F
`define TCS_PTR_OFFSET_HI 8'h11
`define TCS_PTR_OFFSET_LO 8'h12
`define TCS_PTR_CHAN 8'h16
`define TCS_PTR_FAULT 8'h22
`define TCS_PTR_IDEAL 8'h23
`define TCS_PTR_MAKER 8'hFE

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define TCS_CFG_SHUTDOWN_BIT 6
`define TCS_STATUS_BUSY_BIT 7
`define TCS_CHAN_LOCAL_BIT 0
`define TCS_CHAN_REMOTE_BIT 1
`define TCS_RATE_RESET 8'h08
`define TCS_RATE_MAX 8'h08
`define TCS_FAULT_RESET 4'h1
`define TCS_IDEAL_RESET 8'h00
`define TCS_CHAN_RESET 2'h3
`define TCS_MAKER_ID_DEFAULT 8'hA7

// ----------------------------------------
// arithmetic and timing
// ----------------------------------------
`define TCS_KELVIN_OFFSET 18'sh11126
`define TCS_RECIP_2088 14'sh1F63
`define TCS_RECIP_SHIFT 24
`define TCS_CLK_HZ 25000000
`define TCS_CONV_TIME_US 15000
`define TCS_SLOWEST_PERIOD_S 16

`endif

// >>> tcs_pkg.sv
// types shared by the conversion scheduler modules
`default_nettype none
package tcs_pkg;
  typedef enum logic [1:0] {
    TCS_ST_SHUTDOWN,
    TCS_ST_LOCAL,
    TCS_ST_REMOTE,
    TCS_ST_WAIT
  } tcs_state_t;
endpackage : tcs_pkg
`default_nettype wire

// >>> tcs_if.sv
// interfaces between the scheduler top and its sequencer and fault counter
`default_nettype none
interface tcs_sched_if;
  logic shutdown;
  logic oneshot;
  logic [7:0] rate_code;
  logic local_on;
  logic remote_on;
  logic busy;
  logic local_done;
  logic remote_done;
  tcs_pkg::tcs_state_t state;
  modport ctrl (output shutdown, oneshot, rate_code, local_on, remote_on,
                input busy, local_done, remote_done, state);
  modport seq (input shutdown, oneshot, rate_code, local_on, remote_on,
               output busy, local_done, remote_done, state);
endinterface : tcs_sched_if

interface tcs_fault_if;
  logic [1:0] sample;
  logic [3:0] trip;
  logic [2:0] need;
  logic alert;
  modport ctrl (output sample, trip, need, input alert);
  modport cnt (input sample, trip, need, output alert);
endinterface : tcs_fault_if
`default_nettype wire

// >>> tcs_sched.sv
// conversion sequencer: channel order, conversion length and rate interval
`include "tcs_map.svh"
`default_nettype none
module tcs_sched #(
  parameter int unsigned CONV_CYCLES = 375000,
  parameter int unsigned SLOW_PERIOD = 400000000
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  tcs_sched_if.seq s
);
  tcs_pkg::tcs_state_t state_q;
  tcs_pkg::tcs_state_t first_st;
  logic [31:0] conv_cnt_q;
  logic [31:0] period_cnt_q;
  logic [31:0] period_target;
  logic [3:0] code;
  logic oneshot_pend_q;
  logic conv_end;
  logic start_seq;

  assign code = (s.rate_code > `TCS_RATE_MAX) ? 4'(`TCS_RATE_MAX) : s.rate_code[3:0];
  assign period_target = SLOW_PERIOD >> code;
  assign conv_end = conv_cnt_q == CONV_CYCLES - 1;
  assign first_st = s.local_on ? tcs_pkg::TCS_ST_LOCAL :
                    (s.remote_on ? tcs_pkg::TCS_ST_REMOTE : tcs_pkg::TCS_ST_WAIT);
  assign start_seq = (state_q == tcs_pkg::TCS_ST_SHUTDOWN && (!s.shutdown || oneshot_pend_q)) ||
                     (state_q == tcs_pkg::TCS_ST_WAIT && !s.shutdown && period_cnt_q >= period_target - 1);
  assign s.busy = state_q == tcs_pkg::TCS_ST_LOCAL || state_q == tcs_pkg::TCS_ST_REMOTE;
  assign s.state = state_q;

  // ----------------------------------------
  // sequence state
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_q <= tcs_pkg::TCS_ST_SHUTDOWN;
    else if (start_seq)
      state_q <= first_st;
    else
      case (state_q)
        tcs_pkg::TCS_ST_LOCAL:
          if (conv_end)
            state_q <= s.remote_on ? tcs_pkg::TCS_ST_REMOTE : tcs_pkg::TCS_ST_WAIT;
        tcs_pkg::TCS_ST_REMOTE:
          if (conv_end)
            state_q <= tcs_pkg::TCS_ST_WAIT;
        tcs_pkg::TCS_ST_WAIT:
          if (s.shutdown)
            state_q <= tcs_pkg::TCS_ST_SHUTDOWN;
        default:
          state_q <= state_q;
      endcase
  end

  // one-shot request only counts while resting in shutdown
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      oneshot_pend_q <= 1'b0;
    else if (state_q != tcs_pkg::TCS_ST_SHUTDOWN)
      oneshot_pend_q <= 1'b0;
    else if (s.oneshot && s.shutdown)
      oneshot_pend_q <= 1'b1;
    else if (start_seq)
      oneshot_pend_q <= 1'b0;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      conv_cnt_q <= 32'h0;
    else if (!s.busy || conv_end)
      conv_cnt_q <= 32'h0;
    else
      conv_cnt_q <= conv_cnt_q + 32'h1;
  end

  // interval runs from sequence start, so the rate only stretches idle time
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      period_cnt_q <= 32'h0;
    else if (start_seq)
      period_cnt_q <= 32'h0;
    else if (period_cnt_q != 32'hFFFFFFFF)
      period_cnt_q <= period_cnt_q + 32'h1;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s.local_done <= 1'b0;
      s.remote_done <= 1'b0;
    end
    else
    begin
      s.local_done <= state_q == tcs_pkg::TCS_ST_LOCAL && conv_end;
      s.remote_done <= state_q == tcs_pkg::TCS_ST_REMOTE && conv_end;
    end
  end

  oneshot_ignored_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    s.oneshot && state_q != tcs_pkg::TCS_ST_SHUTDOWN |=> !oneshot_pend_q)
    else $error("one-shot accepted while running");
  chan_skip_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    start_seq && !s.local_on |=> state_q != tcs_pkg::TCS_ST_LOCAL)
    else $error("disabled local channel converted");
  conv_len_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $rose(s.local_done) |-> $past(conv_cnt_q) == CONV_CYCLES - 1)
    else $error("conversion length wrong");
  oneshot_cover: cover property (@(posedge i_clock) disable iff (i_sys_rst)
    state_q == tcs_pkg::TCS_ST_WAIT && s.shutdown ##1 state_q == tcs_pkg::TCS_ST_SHUTDOWN);
endmodule : tcs_sched
`default_nettype wire

// >>> tcs_fault.sv
// consecutive out-of-limit counters, one per channel and limit
`default_nettype none
module tcs_fault #(
  parameter int unsigned NUM_CNT = 4
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  tcs_fault_if.cnt f
);
  logic [2:0] cnt_q [NUM_CNT];
  logic [NUM_CNT-1:0] hit;

  for (genvar i = 0; i < NUM_CNT; i++)
  begin : g_cnt
    always_ff @(posedge i_clock or posedge i_sys_rst)
    begin
      if (i_sys_rst)
        cnt_q[i] <= 3'h0;
      else if (f.sample[i/2])
      begin
        if (!f.trip[i])
          cnt_q[i] <= 3'h0;
        else if (cnt_q[i] < 3'h4)
          cnt_q[i] <= cnt_q[i] + 3'h1;
      end
    end
    assign hit[i] = cnt_q[i] >= f.need;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      f.alert <= 1'b0;
    else
      f.alert <= |hit;
  end

  alert_cause_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    $rose(f.alert) |-> $past(|hit))
    else $error("alert without enough faults");
  clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    f.sample[0] && !f.trip[0] |=> cnt_q[0] == 3'h0)
    else $error("counter kept after in-limit result");
  alert_cover: cover property (@(posedge i_clock) disable iff (i_sys_rst) $rose(f.alert));
endmodule : tcs_fault
`default_nettype wire

// >>> tcs_top.sv
// conversion scheduler top: pointer registers, result adjustment and alert
`include "tcs_map.svh"
`default_nettype none
module tcs_top #(
  parameter int unsigned CLK_HZ = `TCS_CLK_HZ,
  parameter int unsigned CONV_CYCLES = CLK_HZ / 1000000 * `TCS_CONV_TIME_US,
  parameter int unsigned SLOW_PERIOD = CLK_HZ * `TCS_SLOWEST_PERIOD_S,
  parameter logic [7:0] MAKER_ID = `TCS_MAKER_ID_DEFAULT // arbitrary value
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_ptr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic [15:0] i_local_raw,
  input wire logic [15:0] i_remote_raw,
  input wire logic [1:0] i_local_trip,
  input wire logic [1:0] i_remote_trip,
  output logic o_conv_local,
  output logic o_conv_remote,
  output logic o_busy,
  output logic o_result_strobe,
  output logic [15:0] o_local_temp,
  output logic [15:0] o_remote_temp,
  output logic o_alert_n
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] rate_q;
  logic shutdown_request_q;
  logic local_channel_on_q;
  logic remote_channel_on_q;
  logic [3:0] fault_code_q;
  logic signed [7:0] ideal_q;
  logic [15:0] offset_q;
  logic oneshot_q;
  logic wr_rate;
  logic wr_chan;
  logic [2:0] need;

  tcs_sched_if sif ();
  tcs_fault_if fif ();

  assign wr_rate = i_reg_wr && i_reg_ptr == `TCS_PTR_RATE_WR;
  assign wr_chan = i_reg_wr && i_reg_ptr == `TCS_PTR_CHAN;

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      rate_q <= `TCS_RATE_RESET;
    else if (wr_rate)
      rate_q <= i_reg_wdata;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      shutdown_request_q <= 1'b0;
    else if (i_reg_wr && i_reg_ptr == `TCS_PTR_CONFIG_WR)
      shutdown_request_q <= i_reg_wdata[`TCS_CFG_SHUTDOWN_BIT];
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      local_channel_on_q <= 1'(`TCS_CHAN_RESET >> `TCS_CHAN_LOCAL_BIT);
      remote_channel_on_q <= 1'(`TCS_CHAN_RESET >> `TCS_CHAN_REMOTE_BIT);
    end
    else if (wr_chan)
    begin
      local_channel_on_q <= i_reg_wdata[`TCS_CHAN_LOCAL_BIT];
      remote_channel_on_q <= i_reg_wdata[`TCS_CHAN_REMOTE_BIT];
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      fault_code_q <= `TCS_FAULT_RESET;
    else if (i_reg_wr && i_reg_ptr == `TCS_PTR_FAULT)
      fault_code_q <= i_reg_wdata[3:0];
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      ideal_q <= `TCS_IDEAL_RESET;
    else if (i_reg_wr && i_reg_ptr == `TCS_PTR_IDEAL)
      ideal_q <= i_reg_wdata;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      offset_q <= 16'h0000;
    else if (i_reg_wr && i_reg_ptr == `TCS_PTR_OFFSET_HI)
      offset_q[15:8] <= i_reg_wdata;
    else if (i_reg_wr && i_reg_ptr == `TCS_PTR_OFFSET_LO)
      offset_q[7:0] <= i_reg_wdata;
  end

  // one-shot keeps only the write event, the byte is dropped
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      oneshot_q <= 1'b0;
    else
      oneshot_q <= i_reg_wr && i_reg_ptr == `TCS_PTR_ONESHOT;
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      if (i_reg_ptr == `TCS_PTR_RATE_RD)
        o_reg_rdata <= rate_q;
      else if (i_reg_ptr == `TCS_PTR_STATUS)
        o_reg_rdata <= {o_busy, 7'h00};
      else if (i_reg_ptr == `TCS_PTR_CONFIG_RD)
        o_reg_rdata <= {1'b0, shutdown_request_q, 6'h00};
      else if (i_reg_ptr == `TCS_PTR_CHAN)
        o_reg_rdata <= {6'h00, remote_channel_on_q, local_channel_on_q};
      else if (i_reg_ptr == `TCS_PTR_FAULT)
        o_reg_rdata <= {4'h0, fault_code_q};
      else if (i_reg_ptr == `TCS_PTR_IDEAL)
        o_reg_rdata <= ideal_q;
      else if (i_reg_ptr == `TCS_PTR_OFFSET_HI)
        o_reg_rdata <= offset_q[15:8];
      else if (i_reg_ptr == `TCS_PTR_OFFSET_LO)
        o_reg_rdata <= offset_q[7:0];
      else if (i_reg_ptr == `TCS_PTR_MAKER)
        o_reg_rdata <= MAKER_ID;
      else
        o_reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign sif.shutdown = shutdown_request_q;
  assign sif.oneshot = oneshot_q;
  assign sif.rate_code = rate_q;
  assign sif.local_on = local_channel_on_q;
  assign sif.remote_on = remote_channel_on_q;

  tcs_sched #(
    .CONV_CYCLES(CONV_CYCLES),
    .SLOW_PERIOD(SLOW_PERIOD)
  ) u_sched (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .s(sif.seq)
  );

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_busy <= 1'b0;
      o_conv_local <= 1'b0;
      o_conv_remote <= 1'b0;
    end
    else
    begin
      o_busy <= sif.busy;
      o_conv_local <= sif.state == tcs_pkg::TCS_ST_LOCAL;
      o_conv_remote <= sif.state == tcs_pkg::TCS_ST_REMOTE;
    end
  end

  // ----------------------------------------
  // remote adjustment
  // ----------------------------------------
  // result scales by (2088+adj)/2088 in kelvin; reciprocal multiply avoids a divider
  logic signed [17:0] kelvin;
  logic signed [25:0] kel_adj;
  logic signed [39:0] kel_scaled;
  logic signed [39:0] corr_full;
  logic [15:0] remote_adj;

  assign kelvin = 18'(signed'(i_remote_raw)) + `TCS_KELVIN_OFFSET;
  assign kel_adj = 26'(kelvin * ideal_q);
  assign kel_scaled = 40'(kel_adj * `TCS_RECIP_2088);
  assign corr_full = kel_scaled >>> `TCS_RECIP_SHIFT;
  assign remote_adj = i_remote_raw + corr_full[15:0] + offset_q;

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_local_temp <= 16'h0000;
    else if (sif.local_done)
      o_local_temp <= i_local_raw;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_remote_temp <= 16'h0000;
    else if (sif.remote_done)
      o_remote_temp <= remote_adj;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_result_strobe <= 1'b0;
    else
      o_result_strobe <= sif.local_done || sif.remote_done;
  end

  // ----------------------------------------
  // consecutive fault alert
  // ----------------------------------------
  always_comb
  begin
    need = 3'(fault_code_q[0]) + 3'(fault_code_q[1]) + 3'(fault_code_q[2]) + 3'(fault_code_q[3]);
    if (need == 3'h0)
      need = 3'h1;
  end

  assign fif.sample = {sif.remote_done, sif.local_done};
  assign fif.trip = {i_remote_trip, i_local_trip};
  assign fif.need = need;

  tcs_fault #(
    .NUM_CNT(4)
  ) u_fault (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .f(fif.cnt)
  );

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_alert_n <= 1'b1;
    else
      o_alert_n <= !fif.alert;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  rate_reset_a: assert property (@(posedge i_clock)
    $fell(i_sys_rst) |-> rate_q == 8'h08 && fault_code_q == 4'h1 && ideal_q == 8'h00)
    else $error("reset values wrong");
  rate_alias_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    wr_rate ##1 !wr_rate ##1 i_reg_rd && i_reg_ptr == 8'h04 && !i_reg_wr |=> o_reg_rdata == $past(i_reg_wdata, 3))
    else $error("rate write not seen at read pointer");
  maker_read_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    i_reg_rd && i_reg_ptr == 8'hFE |=> o_reg_rdata == MAKER_ID)
    else $error("maker id read wrong");
  chan_bits_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    wr_chan |=> local_channel_on_q == $past(i_reg_wdata[0]) && remote_channel_on_q == $past(i_reg_wdata[1]))
    else $error("channel enable bits misplaced");
  busy_track_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    o_busy == $past(sif.busy))
    else $error("busy status does not follow conversion");
  oneshot_start_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    shutdown_request_q && oneshot_q && sif.state == tcs_pkg::TCS_ST_SHUTDOWN && local_channel_on_q
    && $stable(shutdown_request_q) |-> ##2 sif.state == tcs_pkg::TCS_ST_LOCAL)
    else $error("one-shot did not start a conversion");
  ideal_zero_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    sif.remote_done && ideal_q == 8'h00 |=> o_remote_temp == $past(i_remote_raw + offset_q))
    else $error("zero adjust changed result");
  alert_one_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
    need == 3'h1 && sif.local_done && i_local_trip[0] |-> ##3 !o_alert_n)
    else $error("alert missing after one fault");
  remote_cover: cover property (@(posedge i_clock) disable iff (i_sys_rst) sif.remote_done && ideal_q != 8'h00);
  shutdown_cover: cover property (@(posedge i_clock) disable iff (i_sys_rst) $rose(shutdown_request_q) ##[1:20] o_busy);
endmodule : tcs_top
`default_nettype wire

// >>> tcs_fe_model.sv
// front-end model: raw results and limit trips shown to the scheduler
`default_nettype none
module tcs_fe_model (
  input wire logic i_clock,
  input wire logic i_conv_local,
  input wire logic i_conv_remote,
  input wire logic [15:0] i_lval,
  input wire logic [15:0] i_rval,
  input wire logic [1:0] i_ltrip,
  input wire logic [1:0] i_rtrip,
  output logic [15:0] o_local_raw,
  output logic [15:0] o_remote_raw,
  output logic [1:0] o_local_trip,
  output logic [1:0] o_remote_trip
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog_q = 1'b0;
  always @(posedge i_clock) tog_q <= !tog_q;
  // outside a conversion the lines alternate each clock between the inverted and the held value
  assign o_local_raw = i_conv_local ? i_lval : ~i_lval ^ {16{tog_q}};
  assign o_remote_raw = i_conv_remote ? i_rval : ~i_rval ^ {16{tog_q}};
  assign o_local_trip = i_conv_local ? i_ltrip : ~i_ltrip ^ {2{tog_q}};
  assign o_remote_trip = i_conv_remote ? i_rtrip : ~i_rtrip ^ {2{tog_q}};
endmodule : tcs_fe_model
`default_nettype wire

// >>> tcs_top_tb.sv
// self-checking bench for the conversion scheduler
`default_nettype none
module tcs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CC = 20;
  localparam int unsigned SP = 2560;
  localparam logic [7:0] ID = 8'h3C; // arbitrary value
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] ptr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [15:0] lraw;
  logic [15:0] rraw;
  logic [15:0] lval = 16'h0000;
  logic [15:0] rval = 16'h0000;
  logic [1:0] ltrip = 2'h0;
  logic [1:0] rtrip = 2'h0;
  logic [1:0] lt;
  logic [1:0] rt;
  logic conv_l;
  logic conv_r;
  logic busy;
  logic strobe;
  logic alert_n;
  logic [15:0] ltemp;
  logic [15:0] rtemp;
  logic rd_d = 1'b0;
  logic [15:0] em;
  logic [15:0] rd_q[$];
  logic [31:0] rs = 32'd85041;
  logic [31:0] r;
  logic [7:0] adj;
  logic [15:0] off;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int lcnt = 0;
  int rcnt = 0;
  int bcnt = 0;
  int n;
  int b;
  int k;
  always #20 i_clock = ~i_clock;
  tcs_top #(.CONV_CYCLES(CC), .SLOW_PERIOD(SP), .MAKER_ID(ID)) DUT (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_ptr(ptr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_local_raw(lraw),
    .i_remote_raw(rraw), .i_local_trip(lt), .i_remote_trip(rt), .o_conv_local(conv_l),
    .o_conv_remote(conv_r), .o_busy(busy), .o_result_strobe(strobe), .o_local_temp(ltemp),
    .o_remote_temp(rtemp), .o_alert_n(alert_n));
  tcs_fe_model fe (
    .i_clock(i_clock), .i_conv_local(conv_l), .i_conv_remote(conv_r), .i_lval(lval),
    .i_rval(rval), .i_ltrip(ltrip), .i_rtrip(rtrip), .o_local_raw(lraw),
    .o_remote_raw(rraw), .o_local_trip(lt), .o_remote_trip(rt));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  function logic [15:0] rexp(input logic [15:0] raw, input logic [7:0] a, input logic [15:0] o);
    longint t;
    t = (longint'($signed(raw)) + 69926) * longint'($signed(a)) * 8035;
    return raw + o + 16'(t >>> 24);
  endfunction : rexp
  task end_sim;
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask : cyc
  task wr(input logic [7:0] p, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1'b1;
    ptr <= p;
    wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] p, input logic [7:0] e, input logic [7:0] m);
    @(posedge i_clock);
    i_reg_rd <= 1'b1;
    ptr <= p;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    rd_q.push_back({e, m});
  endtask : rd
  task wb(input logic v, output int c);
    c = 0;
    while (c == 0 || (busy !== v && c < 4000))
    begin
      @(posedge i_clock);
      #1;
      c++;
    end
    if (c >= 4000) errors++;
  endtask : wb
  task ws;
    int c;
    c = 0;
    while (strobe !== 1'b1 && c < 200)
    begin
      @(posedge i_clock);
      #1;
      c++;
    end
    if (c >= 200) errors++;
  endtask : ws
  // ----------------------------------------
  // monitor and watchdog
  // ----------------------------------------
  always @(posedge i_clock) rd_d <= i_reg_rd;
  always @(negedge i_clock)
    if (rd_d)
    begin
      em = rd_q.pop_front();
      chk({24'h0, rdata & em[7:0]}, {24'h0, em[15:8]});
    end
  always @(posedge i_clock)
  begin
    lcnt += (conv_l === 1'b1);
    rcnt += (conv_r === 1'b1);
    bcnt += (busy === 1'b1);
    cycles++;
    if (cycles > 60000)
    begin
      errors++;
      end_sim();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd(8'h04, 8'h08, 8'hFF);
    rd(8'h16, 8'h03, 8'h03);
    rd(8'h22, 8'h01, 8'h0F);
    rd(8'h23, 8'h00, 8'hFF);
    wr(8'hFE, 8'h00);
    rd(8'hFE, ID, 8'hFF);
    rd(8'h30, 8'h00, 8'hFF);
    wr(8'h04, 8'h02);
    rd(8'h04, 8'h08, 8'hFF);
    for (int c = 0; c < 6; c++)
    begin
      wr(8'h0A, 8'(c));
      rd(8'h04, 8'(c), 8'hFF);
      wb(0, n);
      wb(1, n);
      r = rnd();
      wr(8'h0F, r[7:0]);
      wb(0, b);
      wb(1, n);
      // the one-shot write spends the first two busy cycles
      chk(b + 2, 2 * CC);
      chk(b + n + 2, SP >> c);
    end
    wr(8'h0A, 8'h08);
    wr(8'h09, 8'h40);
    rd(8'h03, 8'h40, 8'h40);
    cyc(60);
    k = bcnt;
    cyc(200);
    chk(bcnt, k);
    r = rnd();
    wr(8'h0F, r[7:0]);
    wb(1, n);
    rd(8'h02, 8'h80, 8'h80);
    cyc(60);
    rd(8'h02, 8'h00, 8'h80);
    k = bcnt;
    cyc(200);
    chk(bcnt, k);
    wr(8'h16, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      r = rnd();
      adj = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : r[7:0];
      off = r[31:16];
      rval <= 16'h1900 + {6'h00, r[9:0]};
      wr(8'h23, adj);
      wr(8'h11, off[15:8]);
      wr(8'h12, off[7:0]);
      k = lcnt;
      wr(8'h0F, r[15:8]);
      ws();
      chk({16'h0, rtemp}, {16'h0, rexp(rval, adj, off)});
      chk(lcnt, k);
      rd(8'h23, adj, 8'hFF);
      cyc(40);
    end
    wr(8'h16, 8'h01);
    r = rnd();
    lval <= r[15:0];
    k = rcnt;
    wr(8'h0F, r[23:16]);
    ws();
    chk({16'h0, ltemp}, {16'h0, lval});
    chk(rcnt, k);
    wr(8'h09, 8'h00);
    wr(8'h16, 8'h03);
    for (int i = 0; i < 4; i++)
    begin
      ltrip <= 2'h0;
      rtrip <= 2'h0;
      wb(0, n);
      wb(1, n);
      wb(0, n);
      wb(1, n);
      wb(0, n);
      cyc(3);
      chk({31'h0, alert_n}, 32'h1);
      wr(8'h22, (8'h01 << (i + 1)) - 8'h01);
      {rtrip, ltrip} <= 4'h1 << i;
      k = 0;
      while (alert_n !== 1'b0 && k < 6)
      begin
        wb(1, n);
        wb(0, n);
        cyc(3);
        k++;
      end
      chk(k, i + 1);
    end
    end_sim();
  end
endmodule : tcs_top_tb
`default_nettype wire
